/* shared/ppd_pkg.sv */
// Constants and the state type of the parallel-port DMA control block.
// Assumes a 32-bit classic Wishbone register bus on a 50 MHz clock.
package ppd_pkg;
  // Register byte addresses
  localparam logic [31:0] PPD_INFO_ADDR   = 32'h2200_0000;
  localparam logic [31:0] PPD_IRQEN_ADDR  = 32'h2200_0004;
  localparam logic [31:0] PPD_FLAGS_ADDR  = 32'h2200_0008;
  localparam logic [31:0] PPD_LAUNCH_ADDR = 32'h2200_0010;
  // Capability codes in dma_info_and_control
  localparam logic [3:0]  PPD_FIFO_DEPTH_CODE = 4'h1;
  localparam logic [1:0]  PPD_IO_WIDTH_CODE   = 2'h0;
  localparam logic [1:0]  PPD_CHAN_KIND_CODE  = 2'h1;
  // Control bit positions in dma_info_and_control
  localparam int          PPD_SOFT_CLEAR_BIT = 0;
  localparam int          PPD_ECHO_BIT       = 1;
  // Bit positions in receive_channel_launch
  localparam int          PPD_MST_EN_BIT     = 0;
  localparam int          PPD_SLV_EN_BIT     = 1;
  localparam int          PPD_ERR_EN_BIT     = 3;
  localparam logic [31:0] PPD_LAUNCH_MASK    = 32'h0000_000B;
  // Per-channel flag positions; transmit flags sit 16 above receive
  localparam int          PPD_F_EMPTY = 0;
  localparam int          PPD_F_FULL  = 1;
  localparam int          PPD_F_ENTRY = 2;
  localparam int          PPD_F_STALL = 3;
  localparam int          PPD_F_RTY   = 4;
  localparam int          PPD_F_IOREQ = 5;
  localparam int          PPD_F_DONE  = 7;
  localparam int          PPD_F_SERR  = 8;
  localparam int          PPD_F_MERR  = 9;
  localparam int          PPD_F_IOIRQ = 12;
  localparam int          PPD_TX_BASE = 16;
  localparam logic [31:0] PPD_FLAG_MASK = 32'h13BF_13BF;
  localparam logic [31:0] PPD_RX_FLAGS  = 32'h0000_FFFF;
  // Reset values
  localparam logic [31:0] PPD_IRQEN_RST  = 32'h0000_0000;
  localparam logic [31:0] PPD_FLAGS_RST  = 32'h0000_0000;
  localparam logic [31:0] PPD_LAUNCH_RST = 32'h0000_0000;
  // FIFOs sit empty after reset, so no false empty edge follows it
  localparam logic [3:0]  PPD_LVL_RST    = 4'h5;
  // Widest legal slave access size code (word)
  localparam logic [2:0]  PPD_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic        echo;
    logic        clear_pend;
    logic        soft_clear;
    logic [31:0] irq_en;
    logic [31:0] flags;
    logic [31:0] launch;
    logic        flush;
    logic        ack;
    logic [31:0] rdata;
    logic [3:0]  lvl_prev;
    logic        push;
    logic [7:0]  push_data;
  } ppd_state_t;
endpackage

/* hw/ppd_ctrl.sv */
// Control and status registers of the two-channel parallel-port DMA unit.
// Assumes the FIFOs, arbiter and AHB logic sit beside it on the same clock
// and report events as one-cycle pulses and FIFO state as levels.
module ppd_ctrl
  import ppd_pkg::*;
#(
  // Arbitrary value, identifies nothing
  parameter logic [7:0] REVISION = 8'h5A
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        AHB_BUSY_I,
  output logic             SOFT_RESET_O,
  output logic             IRQ_O,
  input  wire logic        TX_IO_IRQ_I,
  input  wire logic        RX_IO_IRQ_I,
  input  wire logic        MST_ERR_RESP_I,
  input  wire logic        TX_GRANT_I,
  input  wire logic        RX_GRANT_I,
  input  wire logic        TX_SLV_ACC_I,
  input  wire logic        TX_SLV_WRITE_I,
  input  wire logic [2:0]  TX_SLV_HSIZE_I,
  input  wire logic        TRANSMIT_RETRY_EXPIRY_FLAG_EXP_I,
  input  wire logic        TX_ERR_EN_I,
  input  wire logic        TX_MST_EN_I,
  output logic             TX_SLV_ERR_O,
  input  wire logic        RX_SLV_ACC_I,
  input  wire logic        RX_SLV_WRITE_I,
  input  wire logic [2:0]  RX_SLV_HSIZE_I,
  input  wire logic        RECEIVE_RETRY_EXPIRY_FLAG_EXP_I,
  output logic             RX_SLV_ERR_O,
  output logic             RX_SLV_RETRY_O,
  input  wire logic        TX_DONE_I,
  input  wire logic        RX_DONE_I,
  input  wire logic        RX_LAST_DONE_I,
  input  wire logic        TX_ACTIVE_I,
  input  wire logic        TX_IO_REQ_I,
  input  wire logic        TX_GAP_I,
  input  wire logic        TX_FIFO_EMPTY_I,
  input  wire logic        TX_FIFO_FULL_I,
  input  wire logic        TX_STALL_I,
  input  wire logic        TX_ENTRY_TRIG_I,
  input  wire logic        RX_IO_REQ_I,
  input  wire logic        RX_GAP_I,
  input  wire logic        RX_ACK_TO_I,
  input  wire logic        RX_FIFO_EMPTY_I,
  input  wire logic        RX_FIFO_FULL_I,
  input  wire logic        RX_STALL_I,
  input  wire logic        RX_ENTRY_TRIG_I,
  input  wire logic [7:0]  TX_POP_DATA_I,
  input  wire logic        TX_POP_VALID_I,
  output logic             TX_POP_O,
  input  wire logic [7:0]  IO_RX_DATA_I,
  input  wire logic        IO_RX_VALID_I,
  output logic             RX_PUSH_O,
  output logic      [7:0]  RX_PUSH_DATA_O,
  output logic             LOOPBACK_O,
  output logic             RX_MASTER_RUN_O,
  output logic             RX_SLAVE_MODE_O,
  output logic             RX_FLUSH_O
);

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  ppd_state_t  q;
  ppd_state_t  d;
  logic        bus_req;
  logic        wr_now;
  logic [31:0] byte_mask;
  logic [31:0] wval;
  logic [31:0] info_word;
  logic [12:0] tx_set;
  logic [12:0] rx_set;
  logic [31:0] set_vec;
  logic [3:0]  lvl_now;
  logic        rx_mst_rise;
  logic        rx_slv_rise;
  logic        rx_active;
  logic        rx_take;

  // Release reset through two flops so every state bit leaves reset together
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  assign bus_req   = WB_CYC_I & WB_STB_I;
  // A write takes effect only at the edge where the master sees ack
  assign wr_now    = bus_req & WB_WE_I & q.ack;
  assign byte_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                      {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wval      = WB_DAT_I & byte_mask;

  assign info_word = {PPD_FIFO_DEPTH_CODE, PPD_IO_WIDTH_CODE,
                      PPD_CHAN_KIND_CODE, PPD_FIFO_DEPTH_CODE,
                      PPD_IO_WIDTH_CODE, PPD_CHAN_KIND_CODE, REVISION,
                      6'h00, q.echo, q.clear_pend};

  assign TX_SLV_ERR_O = TX_SLV_ACC_I & ((TX_ERR_EN_I & TRANSMIT_RETRY_EXPIRY_FLAG_EXP_I)
                        | (TX_SLV_HSIZE_I > PPD_HSIZE_WORD)
                        | ~TX_SLV_WRITE_I | TX_MST_EN_I);
  // error enable picks error over retry on expiry
  assign RX_SLV_ERR_O = RX_SLV_ACC_I
                        & ((q.launch[PPD_ERR_EN_BIT] & RECEIVE_RETRY_EXPIRY_FLAG_EXP_I)
                        | (RX_SLV_HSIZE_I > PPD_HSIZE_WORD)
                        | RX_SLV_WRITE_I | q.launch[PPD_MST_EN_BIT]);
  assign RX_SLV_RETRY_O = RX_SLV_ACC_I & RECEIVE_RETRY_EXPIRY_FLAG_EXP_I & ~RX_SLV_ERR_O;

  // Receive channel is active in either mode
  assign rx_active = q.launch[PPD_MST_EN_BIT] | q.launch[PPD_SLV_EN_BIT];
  assign lvl_now   = {TX_FIFO_FULL_I, TX_FIFO_EMPTY_I,
                      RX_FIFO_FULL_I, RX_FIFO_EMPTY_I};

  always_comb
  begin
    tx_set = 13'h0000;
    rx_set = 13'h0000;
    tx_set[PPD_F_IOIRQ] = TX_IO_IRQ_I;
    rx_set[PPD_F_IOIRQ] = RX_IO_IRQ_I;
    // master error while the channel holds the grant
    tx_set[PPD_F_MERR]  = MST_ERR_RESP_I & TX_GRANT_I;
    rx_set[PPD_F_MERR]  = MST_ERR_RESP_I & RX_GRANT_I;
    tx_set[PPD_F_SERR]  = TX_SLV_ERR_O;
    rx_set[PPD_F_SERR]  = RX_SLV_ERR_O;
    tx_set[PPD_F_DONE]  = TX_DONE_I;
    rx_set[PPD_F_DONE]  = RX_DONE_I;
    tx_set[PPD_F_IOREQ] = TX_ACTIVE_I & TX_IO_REQ_I
                          & (TX_FIFO_EMPTY_I | TX_GAP_I);
    rx_set[PPD_F_IOREQ] = rx_active & RX_IO_REQ_I
                          & (RX_FIFO_FULL_I | RX_GAP_I | RX_ACK_TO_I);
    // retry expiry regardless of error enable
    tx_set[PPD_F_RTY]   = TRANSMIT_RETRY_EXPIRY_FLAG_EXP_I;
    rx_set[PPD_F_RTY]   = RECEIVE_RETRY_EXPIRY_FLAG_EXP_I;
    // data stalled in the channel's FIFO
    tx_set[PPD_F_STALL] = TX_STALL_I;
    rx_set[PPD_F_STALL] = RX_STALL_I;
    tx_set[PPD_F_ENTRY] = TX_ENTRY_TRIG_I;
    rx_set[PPD_F_ENTRY] = RX_ENTRY_TRIG_I;
    // full only on the rising edge of the level
    tx_set[PPD_F_FULL]  = lvl_now[3] & ~q.lvl_prev[3];
    rx_set[PPD_F_FULL]  = lvl_now[1] & ~q.lvl_prev[1];
    // empty only on the rising edge of the level
    tx_set[PPD_F_EMPTY] = lvl_now[2] & ~q.lvl_prev[2];
    rx_set[PPD_F_EMPTY] = lvl_now[0] & ~q.lvl_prev[0];
  end

  assign set_vec = {3'b000, tx_set, 3'b000, rx_set} & PPD_FLAG_MASK;

  always_comb
  begin
    d            = q;
    d.lvl_prev   = lvl_now;
    d.soft_clear = 1'b0;
    d.flush      = 1'b0;
    rx_mst_rise  = 1'b0;
    rx_slv_rise  = 1'b0;
    rx_take      = 1'b0;

    // Bus slave: one wait state, ack for exactly one cycle
    d.ack = bus_req & ~q.ack;
    if (bus_req & ~q.ack)
    begin
      // unmapped and reserved bits read zero
      unique case (WB_ADR_I)
        PPD_INFO_ADDR:   d.rdata = info_word;
        PPD_IRQEN_ADDR:  d.rdata = q.irq_en;
        PPD_FLAGS_ADDR:  d.rdata = q.flags;
        PPD_LAUNCH_ADDR: d.rdata = q.launch;
        default:         d.rdata = 32'h0000_0000;
      endcase
    end

    // logic drops master enable after the last sequence
    if (RX_LAST_DONE_I)
      d.launch[PPD_MST_EN_BIT] = 1'b0;

    // write one clears; set in the same cycle wins
    if (wr_now & (WB_ADR_I == PPD_FLAGS_ADDR))
      d.flags = q.flags & ~wval;
    d.flags = (d.flags | set_vec) & PPD_FLAG_MASK;

    if (wr_now)
    begin
      unique case (WB_ADR_I)
        PPD_INFO_ADDR:
        begin
          if (WB_SEL_I[0])
            d.echo = WB_DAT_I[PPD_ECHO_BIT];
          // request is held until the AHB side is idle
          if (wval[PPD_SOFT_CLEAR_BIT])
            d.clear_pend = 1'b1;
        end
        PPD_IRQEN_ADDR:
          d.irq_en = ((q.irq_en & ~byte_mask) | wval) & PPD_FLAG_MASK;
        PPD_LAUNCH_ADDR:
          d.launch = ((d.launch & ~byte_mask) | wval) & PPD_LAUNCH_MASK;
        default:
          d.launch = d.launch;
      endcase
    end

    // master enable rise, or slave enable rise with master clear, flushes receive FIFO and low flags
    rx_mst_rise = d.launch[PPD_MST_EN_BIT] & ~q.launch[PPD_MST_EN_BIT];
    rx_slv_rise = d.launch[PPD_SLV_EN_BIT] & ~q.launch[PPD_SLV_EN_BIT]
                  & ~d.launch[PPD_MST_EN_BIT];
    if (rx_mst_rise | rx_slv_rise)
    begin
      d.flush = 1'b1;
      d.flags = d.flags & ~PPD_RX_FLAGS;
    end

    // echo source, else the IO block feeds the receive FIFO
    if (q.echo)
      rx_take = TX_POP_VALID_I & ~RX_FIFO_FULL_I;
    else
      rx_take = IO_RX_VALID_I & ~RX_FIFO_FULL_I & rx_active;
    d.push = rx_take;
    if (rx_take)
      d.push_data = q.echo ? TX_POP_DATA_I : IO_RX_DATA_I;

    // engine clear once no AHB transfer is in flight
    if (q.clear_pend & ~AHB_BUSY_I)
    begin
      d.clear_pend = 1'b0;
      d.soft_clear = 1'b1;
      d.echo       = 1'b0;
      d.irq_en     = PPD_IRQEN_RST;
      d.flags      = PPD_FLAGS_RST;
      d.launch     = PPD_LAUNCH_RST;
      d.push       = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q            <= '0;
      q.irq_en     <= PPD_IRQEN_RST;
      q.flags      <= PPD_FLAGS_RST;
      q.launch     <= PPD_LAUNCH_RST;
      q.lvl_prev   <= PPD_LVL_RST;
    end
    else
      q <= d;
  end

  assign WB_DAT_O        = q.rdata;
  assign WB_ACK_O        = q.ack;
  assign SOFT_RESET_O    = q.soft_clear;
  // any enabled flag raises the interrupt
  assign IRQ_O           = |(q.flags & q.irq_en);
  assign LOOPBACK_O      = q.echo;
  // pop the transmit FIFO whenever echo data is offered and the receive FIFO is not full
  assign TX_POP_O        = q.echo & TX_POP_VALID_I & ~RX_FIFO_FULL_I;
  assign RX_PUSH_O       = q.push;
  assign RX_PUSH_DATA_O  = q.push_data;
  // master mode takes priority over slave mode
  assign RX_MASTER_RUN_O = q.launch[PPD_MST_EN_BIT];
  // slave mode only with master enable clear
  assign RX_SLAVE_MODE_O = q.launch[PPD_SLV_EN_BIT]
                           & ~q.launch[PPD_MST_EN_BIT];
  assign RX_FLUSH_O      = q.flush;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!rst_n);

  sequence flag_write_s;
    WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O
      && WB_ADR_I == PPD_FLAGS_ADDR;
  endsequence

  sequence launch_rise_s;
    !q.launch[PPD_MST_EN_BIT] ##1 q.launch[PPD_MST_EN_BIT];
  endsequence

  bus_ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  irq_gate_a: assert property ((q.flags[PPD_F_IOIRQ]
      && q.irq_en[PPD_F_IOIRQ]) |-> IRQ_O)
    else $error("enabled flag did not raise interrupt");
  set_wins_a: assert property ((flag_write_s and RX_IO_IRQ_I
      && !q.clear_pend && !(rx_mst_rise || rx_slv_rise))
      |=> q.flags[PPD_F_IOIRQ])
    else $error("flag event lost during clear");
  flag_clear_a: assert property ((flag_write_s and WB_SEL_I[0]
      && WB_DAT_I[PPD_F_STALL] && !RX_STALL_I)
      |=> !q.flags[PPD_F_STALL])
    else $error("write one did not clear flag");
  echo_move_a: assert property ((q.echo && TX_POP_VALID_I
      && !RX_FIFO_FULL_I && !q.clear_pend) |-> TX_POP_O
      ##1 (RX_PUSH_O && RX_PUSH_DATA_O == $past(TX_POP_DATA_I)))
    else $error("loop-back byte not moved");
  clear_wait_a: assert property ((q.clear_pend && AHB_BUSY_I)
      |=> !SOFT_RESET_O)
    else $error("soft reset during AHB transfer");
  clear_go_a: assert property ((q.clear_pend && !AHB_BUSY_I)
      |=> SOFT_RESET_O ##1 !SOFT_RESET_O)
    else $error("soft reset not a single pulse");
  rx_serr_a: assert property ((RX_SLV_ACC_I && RX_SLV_WRITE_I
      && !q.clear_pend && !rx_mst_rise && !rx_slv_rise)
      |-> RX_SLV_ERR_O ##1 q.flags[PPD_F_SERR])
    else $error("receive write not refused");
  tx_serr_a: assert property ((TX_SLV_ACC_I && !TX_SLV_WRITE_I)
      |-> TX_SLV_ERR_O)
    else $error("transmit read not refused");
  flush_rise_a: assert property (launch_rise_s |-> RX_FLUSH_O
      && q.flags[PPD_F_IOIRQ:0] == 13'h0000)
    else $error("enable rise did not flush");
  last_done_a: assert property ((RX_LAST_DONE_I && !wr_now)
      |=> !RX_MASTER_RUN_O)
    else $error("master enable not dropped");

endmodule // ppd_ctrl

/* dv/ppd_io_side.sv */
// Far-side model: head of the transmit FIFO as the loop-back path sees it.
// Assumes the block's clock and active-low reset.
module ppd_io_side (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic       pop_i,
  output logic      [7:0] data_o,
  output logic            valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;

  assign valid_o = en_i;
  // Idle head shows the inverse so a stale byte never passes
  assign data_o  = en_i ? cnt_q : ~cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= 8'hA0;
    else if (pop_i && en_i)
      cnt_q <= cnt_q + 8'h01;
  end
endmodule // ppd_io_side

/* dv/parallel_port_dma_channel_control_test.sv */
// Self-checking bench for the DMA control block over classic Wishbone.
// Assumes the event inputs are pulses or levels as the hand-over describes.
module parallel_port_dma_channel_control_test
  import ppd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary revision, identifies nothing
  localparam logic [7:0]  REV = 8'hC3;
  localparam logic [31:0] INFO = {PPD_FIFO_DEPTH_CODE, PPD_IO_WIDTH_CODE,
    PPD_CHAN_KIND_CODE, PPD_FIFO_DEPTH_CODE, PPD_IO_WIDTH_CODE,
    PPD_CHAN_KIND_CODE, REV, 8'h00};
  localparam logic [31:0] AI = PPD_INFO_ADDR;
  localparam logic [31:0] AE = PPD_IRQEN_ADDR;
  localparam logic [31:0] AF = PPD_FLAGS_ADDR;
  localparam logic [31:0] AL = PPD_LAUNCH_ADDR;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        pen = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] adr = 32'h0, wdat = 32'h0, ev = 32'h0, q, rdat;
  logic [17:0] lv = 18'h0;
  logic [2:0]  sz = 3'h2, outs;
  logic [7:0]  io_d = 8'h00, head, pdat, cap;
  logic        head_v, ack, srst, irq, tx_err, rx_err, receive_retry_expiry_flag;
  logic        pop, push, lpb, run, slv, flush;
  int          mismatches = 0, samples_checked = 0;

  initial
  begin
    forever #10 clk = ~clk;
  end

  ppd_io_side far (.clk_i(clk), .rst_n_i(rst_n), .en_i(pen), .pop_i(pop),
    .data_o(head), .valid_o(head_v));

  ppd_ctrl #(.REVISION(REV)) dut (
    .SYS_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .AHB_BUSY_I(lv[16]),
    .SOFT_RESET_O(srst), .IRQ_O(irq), .TX_IO_IRQ_I(ev[28]),
    .RX_IO_IRQ_I(ev[12]), .MST_ERR_RESP_I(lv[0]), .TX_GRANT_I(lv[1]),
    .RX_GRANT_I(lv[2]), .TX_SLV_ACC_I(lv[3]), .TX_SLV_WRITE_I(lv[4]),
    .TX_SLV_HSIZE_I(sz), .TRANSMIT_RETRY_EXPIRY_FLAG_EXP_I(ev[20]), .TX_ERR_EN_I(lv[5]),
    .TX_MST_EN_I(lv[6]), .TX_SLV_ERR_O(tx_err), .RX_SLV_ACC_I(lv[7]),
    .RX_SLV_WRITE_I(lv[8]), .RX_SLV_HSIZE_I(sz), .RECEIVE_RETRY_EXPIRY_FLAG_EXP_I(ev[4]),
    .RX_SLV_ERR_O(rx_err), .RX_SLV_RETRY_O(receive_retry_expiry_flag), .TX_DONE_I(ev[23]),
    .RX_DONE_I(ev[7]), .RX_LAST_DONE_I(lv[9]), .TX_ACTIVE_I(lv[10]),
    .TX_IO_REQ_I(lv[11]), .TX_GAP_I(lv[12]), .TX_FIFO_EMPTY_I(ev[16]),
    .TX_FIFO_FULL_I(ev[17]), .TX_STALL_I(ev[19]),
    .TX_ENTRY_TRIG_I(ev[18]), .RX_IO_REQ_I(lv[13]), .RX_GAP_I(lv[14]),
    .RX_ACK_TO_I(lv[15]), .RX_FIFO_EMPTY_I(ev[0]), .RX_FIFO_FULL_I(ev[1]),
    .RX_STALL_I(ev[3]), .RX_ENTRY_TRIG_I(ev[2]), .TX_POP_DATA_I(head),
    .TX_POP_VALID_I(head_v), .TX_POP_O(pop), .IO_RX_DATA_I(io_d),
    .IO_RX_VALID_I(lv[17]), .RX_PUSH_O(push), .RX_PUSH_DATA_O(pdat),
    .LOOPBACK_O(lpb), .RX_MASTER_RUN_O(run), .RX_SLAVE_MODE_O(slv),
    .RX_FLUSH_O(flush));

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Holds the request until ack is sampled high; fails the bench if ack has not come within 15 cycles
  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 16)
    begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [31:0] a, e, input string what);
    wb(1'b0, a, 32'h0);
    check(what, q, e);
  endtask

  // Watches pulse k of {push, soft reset, flush}; stops at the first hit
  task automatic saw(input int k, lim, input logic e, input string what);
    int n;
    logic got;
    logic [2:0] v;
    got = 1'b0;
    n = 0;
    while (!got && n < lim)
    begin
      @(posedge clk);
      v = {push, srst, flush};
      got = v[k];
      cap = pdat;
      n++;
    end
    check(what, {31'h0, got}, {31'h0, e});
  endtask

  task automatic pulse(input logic [31:0] e, input logic [17:0] l,
                       input logic [2:0] s);
    @(posedge clk);
    ev <= e;
    lv <= l;
    sz <= s;
    @(posedge clk);
    outs = {receive_retry_expiry_flag, rx_err, tx_err};
    ev <= 32'h0;
    lv <= 18'h0;
    sz <= 3'h2;
  endtask

  // One event, then flags, interrupt, and write-one-to-clear behaviour
  task automatic fire(input logic [31:0] e, input logic [17:0] l,
                      input logic [2:0] s, o, input logic [31:0] f);
    pulse(e, l, s);
    check("slave answer", {29'h0, outs}, {29'h0, o});
    rd(AF, f, "flags set");
    wb(1'b1, AE, f);
    @(posedge clk);
    check("irq on", {31'h0, irq}, {31'h0, f != 32'h0});
    wb(1'b1, AF, ~f);
    rd(AF, f, "flags kept");
    wb(1'b1, AF, f);
    rd(AF, 32'h0, "flags cleared");
    check("irq off", {31'h0, irq}, 32'h0);
    wb(1'b1, AE, 32'h0);
  endtask

  task automatic t_regs();
    rd(AI, INFO, "info");
    rd(AE, 32'h0, "enables");
    rd(AF, 32'h0, "flags");
    rd(AL, 32'h0, "launch");
    rd(32'h2200_000C, 32'h0, "unmapped");
    wb(1'b1, AE, 32'hFFFF_FFFF);
    rd(AE, 32'h13BF_13BF, "enable mask");
    wb(1'b1, AE, 32'h0);
    wb(1'b1, AI, 32'hFFFF_FFFE);
    rd(AI, INFO | 32'h2, "info echo");
    check("echo out", {31'h0, lpb}, 32'h1);
    wb(1'b1, AI, 32'h0);
  endtask

  task automatic t_events();
    int bits[12] = '{28, 12, 23, 7, 19, 18, 3, 2, 17, 16, 1, 0};
    logic [31:0] b;
    foreach (bits[i])
    begin
      b = 32'h1 << bits[i];
      fire(b, 18'h0, 3'h2, 3'h0, b);
    end
    fire(32'h0001_0000, 18'h00C00, 3'h2, 3'h0, 32'h0021_0000);
    // Event held across the clearing write: the set must win
    ev <= 32'h0000_1000;
    wb(1'b1, AF, 32'h0000_1000);
    ev <= 32'h0;
    rd(AF, 32'h0000_1000, "set wins");
    wb(1'b1, AF, 32'h0000_1000);
  endtask

  task automatic t_master_ioreq();
    fire(32'h0, 18'h00003, 3'h2, 3'h0, 32'h0200_0000);
    fire(32'h0, 18'h00005, 3'h2, 3'h0, 32'h0000_0200);
    fire(32'h0, 18'h00001, 3'h2, 3'h0, 32'h0);
    fire(32'h0, 18'h01C00, 3'h2, 3'h0, 32'h0020_0000);
  endtask

  task automatic t_slave();
    fire(32'h0, 18'h00008, 3'h2, 3'h1, 32'h0100_0000);
    fire(32'h0, 18'h00018, 3'h3, 3'h1, 32'h0100_0000);
    fire(32'h0, 18'h00058, 3'h2, 3'h1, 32'h0100_0000);
    fire(32'h0, 18'h00018, 3'h2, 3'h0, 32'h0);
    fire(32'h0010_0000, 18'h00018, 3'h2, 3'h0, 32'h0010_0000);
    fire(32'h0010_0000, 18'h00038, 3'h2, 3'h1, 32'h0110_0000);
    fire(32'h0, 18'h00180, 3'h2, 3'h2, 32'h0000_0100);
    fire(32'h0, 18'h00080, 3'h3, 3'h2, 32'h0000_0100);
    fire(32'h0, 18'h00080, 3'h2, 3'h0, 32'h0);
    fire(32'h10, 18'h00080, 3'h2, 3'h4, 32'h10);
  endtask

  task automatic t_launch();
    pulse(32'h1000_1000, 18'h0, 3'h2);
    wb(1'b1, AL, 32'h1);
    saw(0, 4, 1'b1, "flush on master");
    check("master run", {31'h0, run}, 32'h1);
    rd(AF, 32'h1000_0000, "flags after flush");
    wb(1'b1, AF, 32'h1000_0000);
    fire(32'h0, 18'h00080, 3'h2, 3'h2, 32'h0000_0100);
    pulse(32'h0, 18'h00200, 3'h2);
    rd(AL, 32'h0, "launch after last");
    wb(1'b1, AL, 32'h2);
    saw(0, 4, 1'b1, "flush on slave");
    check("slave only", {30'h0, run, slv}, 32'h1);
    fire(32'h0, 18'h0A000, 3'h2, 3'h0, 32'h0000_0020);
    fire(32'h0, 18'h06000, 3'h2, 3'h0, 32'h0000_0020);
    wb(1'b1, AL, 32'h3);
    @(posedge clk);
    check("master wins", {30'h0, run, slv}, 32'h2);
    wb(1'b1, AL, 32'h8);
    fire(32'h10, 18'h00080, 3'h2, 3'h2, 32'h0000_0110);
    wb(1'b1, AL, 32'hFFFF_FFFF);
    rd(AL, 32'h0000_000B, "launch mask");
    wb(1'b1, AL, 32'h0);
    wb(1'b1, AF, 32'hFFFF_FFFF);
  endtask

  task automatic t_loop();
    wb(1'b1, AI, 32'h2);
    pen <= 1'b1;
    saw(2, 6, 1'b1, "echo push");
    check("echo byte", {24'h0, cap}, 32'hA0);
    ev <= 32'h2;
    @(posedge clk);
    check("echo next", {23'h0, push, pdat}, 32'h1A1);
    @(posedge clk);
    check("no pop when full", {31'h0, pop}, 32'h0);
    ev <= 32'h0;
    pen <= 1'b0;
    wb(1'b1, AI, 32'h0);
    wb(1'b1, AF, 32'hFFFF_FFFF);
    wb(1'b1, AL, 32'h2);
    io_d <= 8'h3C;
    lv <= 18'h20000;
    @(posedge clk);
    lv <= 18'h0;
    saw(2, 4, 1'b1, "io push");
    check("io byte", {24'h0, cap}, 32'h3C);
    wb(1'b1, AL, 32'h0);
  endtask

  task automatic t_soft();
    wb(1'b1, AE, 32'h1000);
    lv <= 18'h10000;
    wb(1'b1, AI, 32'h1);
    saw(1, 6, 1'b0, "held while busy");
    lv <= 18'h0;
    saw(1, 4, 1'b1, "soft reset pulse");
    rd(AE, 32'h0, "enables cleared");
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_events();
    t_master_ioreq();
    t_slave();
    t_launch();
    t_loop();
    t_soft();
    print_verdict();
  end
endmodule // parallel_port_dma_channel_control_test
